// ---- shared/rwdt_pkg.sv ----
package rwdt_pkg;
  // ----------------------------------------
  // Counter and tap layout
  // ----------------------------------------
  localparam int unsigned COUNT_STAGES = 22;
  localparam logic [1:0] DETECT_TIME_RESET = 2'h0;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic WARM_RESET = 1'b0;
  localparam logic SYSCLK_OUT_ENABLE_RESET = 1'b1;
  localparam logic [7:0] CLEAR_CODE = 8'h4e;
  localparam logic [7:0] DISABLE_CODE = 8'hb1;
  // Tap stage index per detection select, in half-rate counts (2^n/fc = 2^(n-1) ticks)
  localparam int unsigned TAP_SEL0 = 15;
  localparam int unsigned TAP_SEL1 = 17;
  localparam int unsigned TAP_SEL2 = 19;
  localparam int unsigned TAP_SEL3 = 21;
  // Warm-up exponents, in oscillator periods
  localparam int unsigned WARM_EXP_SHORT = 15;
  localparam int unsigned WARM_EXP_LONG = 17;

  // Mode register image written by software
  typedef struct packed {
    logic enable;
    logic [1:0] detect_time;
  } rwdt_mode_type;

  // Clock mode register image
  typedef struct packed {
    logic warm_long;
    logic clk_out_en;
  } rwdt_clkmode_type;
endpackage : rwdt_pkg

// ---- design/rwdt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: 22-stage counter stepped at half oscillator rate
// R2: Two-bit field picks one of four taps
// R3: Detection field resets to shortest interval
// R4: Overflow raises interrupt, drives alarm low
// R5: Interrupt output is non-maskable, no mask
// R6: Alarm stays low until clear code
// R7: Clear code zeroes counter, counting continues
// R8: Enable bit resets to one
// R9: Disable needs enable cleared then code
// R10: Setting enable bit resumes operation at once
// R11: Software clears counter before overflow
// R12: Counting starts right after reset release
// R13: Idle and stop hold counter reset
// R14: Counting continues during bus release
// R15: Runs in light standby, may disable
// R16: Warm bit selects 2^15 or 2^17 warm-up
// R17: Clock-output enable low stops clock out
// R18: Field codes 00..11 map 2^16..2^22
// R19: Other command values are ignored
module rwdt_top #(
  parameter int unsigned STAGES = rwdt_pkg::COUNT_STAGES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic mode_wr,
  input wire rwdt_pkg::rwdt_mode_type mode_wdata,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic clkmode_wr,
  input wire rwdt_pkg::rwdt_clkmode_type clkmode_wdata,
  input wire logic deep_standby,
  input wire logic bus_grant_out_n,
  input wire logic sysclk_in,
  output logic runaway_interrupt,
  output logic runaway_alarm_out_n,
  output logic watchdog_active,
  output rwdt_pkg::rwdt_mode_type watchdog_mode_reg,
  output rwdt_pkg::rwdt_clkmode_type clock_mode_reg,
  output logic [17:0] warmup_cycles,
  output logic sysclk_out
);
  import rwdt_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Counter is zeroed while disarmed, so re-enabling starts a full interval
  logic [STAGES-1:0] count_ff, nxt_count;
  logic prescale_ff, nxt_prescale;
  logic armed_ff, nxt_armed;
  logic alarm_n_ff, nxt_alarm_n;
  logic irq_ff, nxt_irq;
  logic tap_prev_ff, nxt_tap_prev;
  rwdt_mode_type mode_ff, nxt_mode;
  rwdt_clkmode_type clkm_ff, nxt_clkm;
  logic [17:0] warm_ff, nxt_warm;
  logic sclk_ff, nxt_sclk;
  logic tap;

  // Tap decode, shared by the edge detector and assertions
  function automatic logic tap_of(input logic [STAGES-1:0] c, input logic [1:0] sel);
    case (sel) // [R18]
      2'h0: tap_of = c[TAP_SEL0];
      2'h1: tap_of = c[TAP_SEL1];
      2'h2: tap_of = c[TAP_SEL2];
      default: tap_of = c[TAP_SEL3];
    endcase
  endfunction : tap_of

  assign tap = tap_of(count_ff, mode_ff.detect_time); // [R2]

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_count = count_ff;
    nxt_prescale = prescale_ff;
    nxt_armed = armed_ff;
    nxt_alarm_n = alarm_n_ff;
    nxt_irq = 1'b0;
    nxt_tap_prev = tap;
    nxt_mode = mode_ff;
    nxt_clkm = clkm_ff;
    // Register writes
    if (mode_wr) begin
      nxt_mode = mode_wdata;
      if (mode_wdata.enable) begin
        nxt_armed = 1'b1; // [R10]
      end
    end
    if (clkmode_wr) begin
      nxt_clkm = clkmode_wdata;
    end
    // Half-rate tick; bus grant state is deliberately not looked at
    nxt_prescale = ~prescale_ff; // [R1] [R14]
    if (armed_ff && prescale_ff) begin
      nxt_count = count_ff + 1'b1; // [R1] [R12]
    end
    if (!armed_ff) begin
      nxt_count = '0;
    end
    // Overflow on rising edge of selected stage
    // Deep standby must not start an alarm on the edge it is entered
    if (armed_ff && tap && !tap_prev_ff && !deep_standby) begin
      nxt_irq = 1'b1; // [R4] [R5]
      nxt_alarm_n = 1'b0; // [R4] [R6]
    end
    // Clear wins over a same-cycle overflow, so software never loses the race
    if (cmd_wr) begin
      if (cmd_wdata == CLEAR_CODE) begin
        nxt_count = '0; // [R7]
        nxt_prescale = 1'b0;
        nxt_alarm_n = 1'b1; // [R6]
        nxt_irq = 1'b0;
      end else if (cmd_wdata == DISABLE_CODE && !mode_ff.enable && !mode_wr) begin
        // Refused while the enable bit is set or being rewritten
        nxt_armed = 1'b0; // [R9] [R15]
      end
      // Any other value leaves state untouched [R19]
    end
    // Deep standby holds the counter in reset
    if (deep_standby) begin
      nxt_count = '0; // [R13]
      nxt_prescale = 1'b0;
      nxt_tap_prev = 1'b0;
      nxt_irq = 1'b0;
    end
  end

  // Warm-up count and clock-out gating
  // The warm-up count is only presented; the standby sequencer times it
  always_comb begin
    nxt_warm = clkm_ff.warm_long ? 18'(1 << WARM_EXP_LONG) : 18'(1 << WARM_EXP_SHORT); // [R16]
    nxt_sclk = clkm_ff.clk_out_en & sysclk_in; // [R17]
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_ff <= '0;
      prescale_ff <= 1'b0;
      armed_ff <= ENABLE_RESET; // [R8] [R12]
      alarm_n_ff <= 1'b1;
      irq_ff <= 1'b0;
      tap_prev_ff <= 1'b0;
      mode_ff <= '{enable: ENABLE_RESET, detect_time: DETECT_TIME_RESET}; // [R3] [R8]
      clkm_ff <= '{warm_long: WARM_RESET, clk_out_en: SYSCLK_OUT_ENABLE_RESET};
      warm_ff <= '0;
      sclk_ff <= 1'b0;
    end else if (clk_en) begin
      count_ff <= nxt_count;
      prescale_ff <= nxt_prescale;
      armed_ff <= nxt_armed;
      alarm_n_ff <= nxt_alarm_n;
      irq_ff <= nxt_irq;
      tap_prev_ff <= nxt_tap_prev;
      mode_ff <= nxt_mode;
      clkm_ff <= nxt_clkm;
      warm_ff <= nxt_warm;
      sclk_ff <= nxt_sclk;
    end
  end

  assign runaway_interrupt = irq_ff;
  assign runaway_alarm_out_n = alarm_n_ff;
  assign watchdog_active = armed_ff;
  assign watchdog_mode_reg = mode_ff;
  assign clock_mode_reg = clkm_ff;
  assign warmup_cycles = warm_ff;
  assign sysclk_out = sclk_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_clear_releases: assert property (@(posedge core_clk) disable iff (reset) // [R6]
    (clk_en && cmd_wr && cmd_wdata == CLEAR_CODE) |=> runaway_alarm_out_n && count_ff == '0)
    else $error("clear code did not release alarm");
  a_alarm_holds: assert property (@(posedge core_clk) disable iff (reset) // [R6]
    (!runaway_alarm_out_n && !(clk_en && cmd_wr && cmd_wdata == CLEAR_CODE))
      |=> !runaway_alarm_out_n)
    else $error("alarm released without clear code");
  a_irq_with_alarm: assert property (@(posedge core_clk) disable iff (reset) // [R4]
    runaway_interrupt |-> !runaway_alarm_out_n)
    else $error("interrupt without alarm");
  a_standby_hold: assert property (@(posedge core_clk) disable iff (reset) // [R13]
    (clk_en && deep_standby) |=> count_ff == '0)
    else $error("counter moved in deep standby");
  a_disable_refused: assert property (@(posedge core_clk) disable iff (reset) // [R9]
    (clk_en && cmd_wr && cmd_wdata == DISABLE_CODE && watchdog_mode_reg.enable)
      |=> watchdog_active)
    else $error("disable code accepted with enable bit set");
  a_disable_cond: assert property (@(posedge core_clk) disable iff (reset) // [R9]
    $fell(watchdog_active) |-> $past(cmd_wr) && $past(cmd_wdata) == DISABLE_CODE
      && !$past(watchdog_mode_reg.enable))
    else $error("watchdog disabled without two-step sequence");
  a_enable_resume: assert property (@(posedge core_clk) disable iff (reset) // [R10]
    (clk_en && mode_wr && mode_wdata.enable) |=> watchdog_active)
    else $error("enable bit did not resume watchdog");
  a_count_rate: assert property (@(posedge core_clk) disable iff (reset) // [R1]
    (clk_en && watchdog_active && !deep_standby && count_ff == '0) ##1 clk_en
      |=> count_ff <= STAGES'(1))
    else $error("counter advanced faster than half rate");
  a_other_ignored: assert property (@(posedge core_clk) disable iff (reset) // [R19]
    (clk_en && cmd_wr && cmd_wdata != CLEAR_CODE && cmd_wdata != DISABLE_CODE && !mode_wr)
      |=> $stable(watchdog_active))
    else $error("stray command changed enable state");
  a_clkout_off: assert property (@(posedge core_clk) disable iff (reset) // [R17]
    (clk_en && !clock_mode_reg.clk_out_en) |=> !sysclk_out)
    else $error("clock out driven while disabled");

  // ----------------------------------------
  // Pulse, alarm and reset checks
  // ----------------------------------------
  // A longer pulse would be taken twice by the processor
  a_irq_pulse: assert property (@(posedge core_clk) disable iff (reset) // [R5]
    (clk_en && runaway_interrupt) |=> !runaway_interrupt)
    else $error("interrupt held longer than one cycle");

  // Interrupt only follows a rising tap while armed
  a_irq_cause: assert property (@(posedge core_clk) disable iff (reset) // [R4]
    $rose(runaway_interrupt) |-> $past(clk_en) && $past(armed_ff) && $past(tap)
      && !$past(tap_prev_ff) && !$past(deep_standby))
    else $error("interrupt without overflow");

  // Alarm drops only together with the interrupt
  a_alarm_cause: assert property (@(posedge core_clk) disable iff (reset) // [R4]
    $fell(runaway_alarm_out_n) |-> runaway_interrupt)
    else $error("alarm dropped without interrupt");

  // Armed with reset images straight after release, no write needed
  a_reset_values: assert property (@(posedge core_clk) // [R3] [R8] [R12]
    $fell(reset) |-> watchdog_mode_reg == {ENABLE_RESET, DETECT_TIME_RESET}
      && watchdog_active && runaway_alarm_out_n && !runaway_interrupt && count_ff == '0)
    else $error("wrong state after reset release");

  // ----------------------------------------
  // Register image checks
  // ----------------------------------------
  // Mode image follows the written value one cycle later
  a_mode_write: assert property (@(posedge core_clk) disable iff (reset) // [R2]
    (clk_en && mode_wr) |=> watchdog_mode_reg == $past(mode_wdata))
    else $error("mode write not taken");

  // Clock mode image follows the written value one cycle later
  a_clkmode_write: assert property (@(posedge core_clk) disable iff (reset) // [R16]
    (clk_en && clkmode_wr) |=> clock_mode_reg == $past(clkmode_wdata))
    else $error("clock mode write not taken");

  // Long warm-up selected by a set warm bit
  a_warm_long: assert property (@(posedge core_clk) disable iff (reset) // [R16]
    (clk_en && clock_mode_reg.warm_long) |=> warmup_cycles == 18'(1 << WARM_EXP_LONG))
    else $error("long warm-up count wrong");

  // Short warm-up selected by a clear warm bit
  a_warm_short: assert property (@(posedge core_clk) disable iff (reset) // [R16]
    (clk_en && !clock_mode_reg.warm_long) |=> warmup_cycles == 18'(1 << WARM_EXP_SHORT))
    else $error("short warm-up count wrong");

  // Enabled clock out follows the system clock level
  a_clkout_on: assert property (@(posedge core_clk) disable iff (reset) // [R17]
    (clk_en && clock_mode_reg.clk_out_en) |=> sysclk_out == $past(sysclk_in))
    else $error("clock out not following system clock");

  // A low clock enable freezes every register
  a_freeze_state: assert property (@(posedge core_clk) disable iff (reset) // [R1]
    !clk_en |=> $stable(count_ff) && $stable(watchdog_mode_reg)
      && $stable(watchdog_active) && $stable(runaway_alarm_out_n))
    else $error("state moved while clock enable low");

  // ----------------------------------------
  // Counting and disable checks
  // ----------------------------------------
  // Bus release must not slow the count, or runaway goes unseen
  a_bus_release: assert property (@(posedge core_clk) disable iff (reset) // [R14]
    (clk_en && watchdog_active && !bus_grant_out_n && !deep_standby && !cmd_wr
      && prescale_ff) |=> count_ff == STAGES'($past(count_ff) + 1'b1))
    else $error("counter stalled during bus release");

  // Disarmed counter sits at zero
  a_off_zero: assert property (@(posedge core_clk) disable iff (reset) // [R9]
    (clk_en && !watchdog_active) |=> count_ff == '0)
    else $error("counter moving while disabled");

  // Disable code refused when the mode register is written alongside
  a_disable_with_write: assert property (@(posedge core_clk) disable iff (reset) // [R9]
    (clk_en && watchdog_active && cmd_wr && cmd_wdata == DISABLE_CODE && mode_wr)
      |=> watchdog_active)
    else $error("disable taken with same-cycle mode write");
endmodule : rwdt_top
`default_nettype wire

// ---- tb/rwdt_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor and peripheral side
// ----------------------------------------
module rwdt_cpu_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic runaway_interrupt,
  input wire logic runaway_alarm_out_n,
  output int nmi_count,
  output logic periph_reset
);
  // No mask bit: every interrupt pulse is taken
  always_ff @(posedge core_clk) begin
    if (reset) nmi_count <= 0;
    else if (runaway_interrupt) nmi_count <= nmi_count + 1;
  end
  // Peripherals sit in reset while the alarm is low
  assign periph_reset = ~runaway_alarm_out_n;
endmodule : rwdt_cpu_model
`default_nettype wire

// ---- tb/test_runaway_watchdog_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h, seen %h", n, e, a); end end
module test_runaway_watchdog_timer;
  import rwdt_pkg::*;
  typedef struct packed {rwdt_clkmode_type cm; logic [17:0] warm; logic out;} rwdt_row_type;
  // Clock mode images beside their warm-up and clock-out results
  rwdt_row_type rows [4] = '{'{2'h1, 18'h08000, 1'b1}, '{2'h3, 18'h20000, 1'b1},
    '{2'h2, 18'h20000, 1'b0}, '{2'h0, 18'h08000, 1'b0}};
  logic core_clk = 0, reset = 1, mode_wr = 0, cmd_wr = 0, clkmode_wr = 0;
  logic deep_standby = 0, bus_grant_out_n = 1, sysclk_in = 1, clk_en = 1;
  logic [7:0] cmd_wdata = 8'h00;
  rwdt_mode_type mode_wdata = '0;
  rwdt_clkmode_type clkmode_wdata = '0;
  logic runaway_interrupt, runaway_alarm_out_n, watchdog_active, sysclk_out, periph_reset;
  rwdt_mode_type watchdog_mode_reg;
  rwdt_clkmode_type clock_mode_reg;
  logic [17:0] warmup_cycles;
  int fail_count = 0, checks = 0, n, nmi_count;
  rwdt_top uut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .clkmode_wr(clkmode_wr), .clkmode_wdata(clkmode_wdata), .deep_standby(deep_standby),
    .bus_grant_out_n(bus_grant_out_n), .sysclk_in(sysclk_in),
    .runaway_interrupt(runaway_interrupt), .runaway_alarm_out_n(runaway_alarm_out_n),
    .watchdog_active(watchdog_active), .watchdog_mode_reg(watchdog_mode_reg),
    .clock_mode_reg(clock_mode_reg), .warmup_cycles(warmup_cycles), .sysclk_out(sysclk_out));
  rwdt_cpu_model cpu (.core_clk(core_clk), .reset(reset), .runaway_interrupt(runaway_interrupt),
    .runaway_alarm_out_n(runaway_alarm_out_n), .nmi_count(nmi_count), .periph_reset(periph_reset));
  // ----------------------------------------
  // Clock, strobed writes and verdict
  // ----------------------------------------
  initial forever #2.5 core_clk = ~core_clk;
  task automatic cmd(input logic [7:0] d);
    cmd_wr <= 1'b1;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : cmd
  task automatic mode(input rwdt_mode_type m);
    mode_wr <= 1'b1;
    mode_wdata <= m;
    @(posedge core_clk);
    mode_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : mode
  task automatic close_out();
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // Hang guard, well beyond the one long overflow wait
  initial begin
    #(90000 * 5);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    `CHK("alarm", 1'b1, runaway_alarm_out_n)
    `CHK("active", ENABLE_RESET, watchdog_active)
    `CHK("mode", {ENABLE_RESET, DETECT_TIME_RESET}, watchdog_mode_reg)
    `CHK("clkmode", {WARM_RESET, SYSCLK_OUT_ENABLE_RESET}, clock_mode_reg)
    // Every detect code and clock mode image in turn
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      clkmode_wdata <= rows[i].cm;
      clkmode_wr <= 1'b1;
      mode(rwdt_mode_type'({1'b1, 2'(i)}));
      clkmode_wr <= 1'b0;
      @(negedge core_clk);
      `CHK("mode", rwdt_mode_type'({1'b1, 2'(i)}), watchdog_mode_reg)
      `CHK("warmup", rows[i].warm, warmup_cycles)
      `CHK("sysclk_out", rows[i].out, sysclk_out)
    end
    // Disable code alone, junk code, then the proper two steps
    @(posedge core_clk);
    mode(rwdt_mode_type'(3'h4));
    cmd(DISABLE_CODE);
    `CHK("active", 1'b1, watchdog_active)
    mode(rwdt_mode_type'(3'h0));
    cmd(8'h12);
    `CHK("active", 1'b1, watchdog_active)
    cmd(DISABLE_CODE);
    `CHK("active", 1'b0, watchdog_active)
    mode(rwdt_mode_type'(3'h4));
    `CHK("active", 1'b1, watchdog_active)
    // Standby holds the count; overflow then timed from release, bus granted away
    bus_grant_out_n <= 1'b0;
    deep_standby <= 1'b1;
    repeat (1000) @(posedge core_clk);
    deep_standby <= 1'b0;
    n = 0;
    while (nmi_count == 0 && n < 70000) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("overflow_time", 1'b1, (n > 65530 && n < 65545))
    @(negedge core_clk);
    `CHK("alarm", 1'b0, runaway_alarm_out_n)
    `CHK("periph_reset", 1'b1, periph_reset)
    repeat (20) @(posedge core_clk);
    `CHK("alarm", 1'b0, runaway_alarm_out_n)
    `CHK("nmi_count", 1, nmi_count)
    cmd(CLEAR_CODE);
    `CHK("alarm", 1'b1, runaway_alarm_out_n)
    // Frozen clock enable ignores a mode write
    clk_en <= 1'b0;
    mode(rwdt_mode_type'(3'h7));
    `CHK("mode_frozen", rwdt_mode_type'(3'h4), watchdog_mode_reg)
    clk_en <= 1'b1;
    // Clock out follows a low system clock level
    clkmode_wdata <= 2'h1;
    clkmode_wr <= 1'b1;
    sysclk_in <= 1'b0;
    mode(rwdt_mode_type'(3'h7));
    clkmode_wr <= 1'b0;
    @(negedge core_clk);
    `CHK("sysclk_out", 1'b0, sysclk_out)
    // Mid-run reset restores the shortest interval and arms at once
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    `CHK("mode", {ENABLE_RESET, DETECT_TIME_RESET}, watchdog_mode_reg)
    `CHK("active", 1'b1, watchdog_active)
    close_out();
  end
endmodule : test_runaway_watchdog_timer
`default_nettype wire
